//--- design/power_mode_manager_defs.svh
`ifndef POWER_MODE_MANAGER_DEFS_SVH
`define POWER_MODE_MANAGER_DEFS_SVH
// register byte offsets
`define OFS_CMD        12'h000
`define OFS_STATUS     12'h004
`define OFS_RETRY      12'h008
`define OFS_GPIO_CFG   12'h00c
`define OFS_GPIO_SAVED 12'h010
`define OFS_CARD       12'h014
// command bit positions
`define CMD_POWER_DOWN 0
`define CMD_ACTIVATE   1
`define CMD_TARGET     2
`define CMD_ABORT      3
`define CMD_STANDBY    4
`define CMD_WAKE       5
// reset values; card mode resets to CARD_HOLD, CARD_RESET is unused
`define RETRY_RESET    8'h03
`define GPIO_CFG_RESET 32'h55555555
`define CARD_RESET     2'h2
// pin and card encodings
`define GPIO_INPUT     2'h0
`define CARD_HOLD      2'h0
// timing
`define WAKE_DELAY_US  500
`define CLK_FREQ_MHZ   25
`endif

//--- design/power_mode_manager_pkg.sv
package power_mode_manager_pkg;
    typedef enum logic [2:0] {cpu_hard_pd, cpu_normal, cpu_saving, cpu_pd, cpu_waking} cpu_mode_t;
    typedef enum logic [2:0] {fe_hard_pd, front_end_active_field_off, front_end_active_field_on,
                              front_end_detector_only, front_end_deepest_off} fe_mode_t;
    typedef enum logic [1:0] {op_standby, op_initiator, op_target} op_mode_t;
    typedef struct packed {
        logic       rst_pd;
        logic       hub_disabled;
        logic       host_suspend;
        logic       target_found;
        logic       target_released;
        logic       attempt_failed;
        logic       wake_event;
        logic [7:0] port_three;
        logic [7:0] port_seven;
    } pins_t;
    typedef struct packed {
        logic cse_reset_n;
        logic afe_reset_n;
        logic cse_en;
        logic afe_en;
        logic det_en;
        logic field_on;
    } fe_ctrl_t;
    typedef struct packed {
        pins_t      s1;
        pins_t      s2;
        logic       prev_fail;
        cpu_mode_t  cpu;
        fe_mode_t   fe;
        op_mode_t   op;
        logic       suspended;
        logic       act_busy;
        logic       act_req;
        logic [7:0] retry_cfg;
        logic [7:0] retry_left;
        logic [31:0] gpio_cfg;
        logic [31:0] gpio_saved;
        logic [31:0] gpio_mode;
        logic [15:0] low_mask;
        logic [15:0] wake_cnt;
        logic [1:0] card;
        logic       cpu_reset_n;
        logic       osc_en;
        fe_ctrl_t   ctl;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage

//--- design/power_mode_manager.sv
`timescale 1ns/1ns
`include "power_mode_manager_defs.svh"
// Overview of operation
// - hard power down only from pin, holds resets
// - cpu power down stops oscillator, 500us wake
// - active modes: engine runs, field off/on
// - detector-only: engine down, detector on, no field
// - deepest mode: everything off, detector disabled
// - card reader: reset, shutdown or normal
// - standby after reset until commanded otherwise
// - after reset cpu normal, front end deepest
// - auto moves by internal event or command
// - suspend on host suspend or hub disable while cpu normal
// - initiator when target activated, initiator commands
// - target operation for target configuration, commands
// - record configuration of externally low pins
// - switch low pins to input before power down
// - restore recorded configuration on wake
// - repeat activation request on each failed attempt until target found or retries run out
// - abort of activation switches field off
// - exhausted retries switch field off
module power_mode_manager #(
    parameter int WAKE_CYCLES = `WAKE_DELAY_US * `CLK_FREQ_MHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_powerdown_pin,
    input  wire logic        hub_port_disabled,
    input  wire logic        host_suspend,
    input  wire logic        target_found,
    input  wire logic        target_released,
    input  wire logic        attempt_failed,
    input  wire logic        wake_event,
    input  wire logic [7:0]  port_three,
    input  wire logic [7:0]  port_seven,
    output logic             cpu_reset_n,
    output logic             osc_enable,
    output logic             cse_reset_n,
    output logic             afe_reset_n,
    output logic             cse_enable,
    output logic             afe_enable,
    output logic             rf_detector_enable,
    output logic             rf_field_on,
    output logic             activation_request,
    output logic             suspended,
    output logic      [1:0]  card_mode,
    output logic      [31:0] gpio_mode
);
    power_mode_manager_pkg::state_t st;
    power_mode_manager_pkg::state_t next_st;
    power_mode_manager_pkg::pins_t  pins_in;
    logic [5:0]  cmd;
    logic        acc;
    logic        commit;
    logic        fail_edge;
    logic [15:0] low_pins;

    function automatic logic mapped(input logic [11:0] a);
        if (a == `OFS_CMD) return 1'b1;
        else if (a == `OFS_STATUS) return 1'b1;
        else if (a == `OFS_RETRY) return 1'b1;
        else if (a == `OFS_GPIO_CFG) return 1'b1;
        else if (a == `OFS_GPIO_SAVED) return 1'b1;
        else if (a == `OFS_CARD) return 1'b1;
        else return 1'b0;
    endfunction

    function automatic power_mode_manager_pkg::fe_ctrl_t fe_ctrl(input power_mode_manager_pkg::fe_mode_t m);
        power_mode_manager_pkg::fe_ctrl_t c;
        c = '0;
        case (m)
            power_mode_manager_pkg::front_end_active_field_off: c = 6'b111100;
            power_mode_manager_pkg::front_end_active_field_on:  c = 6'b111101;
            power_mode_manager_pkg::front_end_detector_only:    c = 6'b110010;
            power_mode_manager_pkg::front_end_deepest_off:      c = 6'b110000;
            default:                                            c = 6'b000000;
        endcase
        return c;
    endfunction

    function automatic logic [31:0] widen(input logic [15:0] m);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < 16; i++)
        begin
            w[2*i] = m[i];
            w[2*i+1] = m[i];
        end
        return w;
    endfunction

    assign pins_in = '{reset_powerdown_pin, hub_port_disabled, host_suspend, target_found,
                       target_released, attempt_failed, wake_event, port_three, port_seven};
    assign low_pins = ~{st.s2.port_seven, st.s2.port_three};
    assign fail_edge = st.s2.attempt_failed & ~st.prev_fail;
    assign acc = psel & penable & ~st.pready;
    assign commit = psel & penable & st.pready & pwrite;
    assign cmd = (commit && paddr == `OFS_CMD) ? pwdata[5:0] : 6'h00;

    always_comb
    begin
        next_st = st;
        next_st.s1 = pins_in;
        next_st.s2 = st.s1;
        next_st.prev_fail = st.s2.attempt_failed;
        next_st.act_req = 1'b0;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        // bus access, one wait state
        if (acc)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = ~mapped(paddr);
            if (pwrite || !mapped(paddr))
                next_st.prdata = 32'h00000000;
            else if (paddr == `OFS_STATUS)
                next_st.prdata = {17'h00000, st.act_busy, st.ctl.field_on, st.suspended,
                                  2'(st.op), 3'(st.fe), 3'(st.cpu), st.card, st.osc_en, st.cpu_reset_n};
            else if (paddr == `OFS_RETRY)
                next_st.prdata = {24'h000000, st.retry_cfg};
            else if (paddr == `OFS_GPIO_CFG)
                next_st.prdata = st.gpio_cfg;
            else if (paddr == `OFS_GPIO_SAVED)
                next_st.prdata = st.gpio_saved;
            else if (paddr == `OFS_CARD)
                next_st.prdata = {30'h00000000, st.card};
            else
                next_st.prdata = 32'h00000000;
        end
        if (commit && paddr == `OFS_RETRY)
            next_st.retry_cfg = pwdata[7:0];
        if (commit && paddr == `OFS_CARD && pwdata[1:0] != 2'h3)
            next_st.card = pwdata[1:0];
        if (commit && paddr == `OFS_GPIO_CFG && st.cpu == power_mode_manager_pkg::cpu_normal)
        begin
            next_st.gpio_cfg = pwdata;
            next_st.gpio_mode = pwdata;
        end
        case (st.cpu)
            power_mode_manager_pkg::cpu_hard_pd:
            begin
                if (st.s2.rst_pd)
                begin
                    next_st.cpu = power_mode_manager_pkg::cpu_normal;
                    next_st.op = power_mode_manager_pkg::op_standby;
                end
            end
            power_mode_manager_pkg::cpu_normal:
            begin
                next_st.suspended = st.s2.hub_disabled | st.s2.host_suspend;
                if (next_st.suspended)
                    next_st.act_busy = 1'b0;
                else if (st.act_busy)
                begin
                    if (st.s2.target_found)
                        next_st.act_busy = 1'b0;
                    else if (cmd[`CMD_ABORT])
                    begin
                        next_st.act_busy = 1'b0;
                        next_st.op = power_mode_manager_pkg::op_standby;
                    end
                    else if (fail_edge)
                    begin
                        if (st.retry_left <= 8'h01)
                        begin
                            next_st.act_busy = 1'b0;
                            next_st.op = power_mode_manager_pkg::op_standby;
                        end
                        else
                        begin
                            next_st.retry_left = st.retry_left - 8'h01;
                            next_st.act_req = 1'b1;
                        end
                    end
                end
                else if (cmd[`CMD_ACTIVATE])
                begin
                    next_st.op = power_mode_manager_pkg::op_initiator;
                    next_st.act_busy = 1'b1;
                    next_st.act_req = 1'b1;
                    next_st.retry_left = st.retry_cfg;
                end
                else if (cmd[`CMD_TARGET])
                    next_st.op = power_mode_manager_pkg::op_target;
                else if (cmd[`CMD_STANDBY] || st.s2.target_released)
                    next_st.op = power_mode_manager_pkg::op_standby;
                else if (cmd[`CMD_POWER_DOWN])
                    next_st.cpu = power_mode_manager_pkg::cpu_saving;
            end
            power_mode_manager_pkg::cpu_saving:
            begin
                next_st.low_mask = low_pins;
                next_st.gpio_saved = st.gpio_cfg;
                next_st.gpio_mode = (st.gpio_mode & ~widen(low_pins)) | 32'h00000000;
                next_st.cpu = power_mode_manager_pkg::cpu_pd;
            end
            power_mode_manager_pkg::cpu_pd:
            begin
                if (st.s2.wake_event || cmd[`CMD_WAKE])
                begin
                    next_st.cpu = power_mode_manager_pkg::cpu_waking;
                    next_st.wake_cnt = 16'h0000;
                end
            end
            power_mode_manager_pkg::cpu_waking:
            begin
                if (st.wake_cnt >= 16'(WAKE_CYCLES - 1))
                begin
                    next_st.cpu = power_mode_manager_pkg::cpu_normal;
                    next_st.gpio_mode = st.gpio_saved;
                    next_st.low_mask = 16'h0000;
                end
                else
                    next_st.wake_cnt = st.wake_cnt + 16'h0001;
            end
            default:
                next_st.cpu = power_mode_manager_pkg::cpu_hard_pd;
        endcase
        if (!st.s2.rst_pd)
        begin
            next_st.cpu = power_mode_manager_pkg::cpu_hard_pd;
            next_st.op = power_mode_manager_pkg::op_standby;
            next_st.act_busy = 1'b0;
            next_st.suspended = 1'b0;
            next_st.card = `CARD_HOLD;
        end
        if (next_st.cpu == power_mode_manager_pkg::cpu_hard_pd)
            next_st.fe = power_mode_manager_pkg::fe_hard_pd;
        else if (next_st.suspended)
            next_st.fe = power_mode_manager_pkg::front_end_deepest_off;
        else if (next_st.cpu != power_mode_manager_pkg::cpu_normal)
            next_st.fe = (next_st.op == power_mode_manager_pkg::op_target) ?
                         power_mode_manager_pkg::front_end_detector_only :
                         power_mode_manager_pkg::front_end_deepest_off;
        else if (next_st.op == power_mode_manager_pkg::op_initiator)
            next_st.fe = power_mode_manager_pkg::front_end_active_field_on;
        else if (next_st.op == power_mode_manager_pkg::op_target)
            next_st.fe = power_mode_manager_pkg::front_end_active_field_off;
        else
            next_st.fe = power_mode_manager_pkg::front_end_deepest_off;
        next_st.ctl = fe_ctrl(next_st.fe);
        next_st.cpu_reset_n = (next_st.cpu != power_mode_manager_pkg::cpu_hard_pd);
        next_st.osc_en = (next_st.cpu != power_mode_manager_pkg::cpu_pd) &&
                         (next_st.cpu != power_mode_manager_pkg::cpu_hard_pd);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.cpu <= power_mode_manager_pkg::cpu_hard_pd;
            st.fe <= power_mode_manager_pkg::fe_hard_pd;
            st.op <= power_mode_manager_pkg::op_standby;
            st.retry_cfg <= `RETRY_RESET;
            st.gpio_cfg <= `GPIO_CFG_RESET;
            st.gpio_saved <= `GPIO_CFG_RESET;
            st.gpio_mode <= `GPIO_CFG_RESET;
            st.card <= `CARD_HOLD;
        end
        else
            st <= next_st;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign cpu_reset_n = st.cpu_reset_n;
    assign osc_enable = st.osc_en;
    assign cse_reset_n = st.ctl.cse_reset_n;
    assign afe_reset_n = st.ctl.afe_reset_n;
    assign cse_enable = st.ctl.cse_en;
    assign afe_enable = st.ctl.afe_en;
    assign rf_detector_enable = st.ctl.det_en;
    assign rf_field_on = st.ctl.field_on;
    assign activation_request = st.act_req;
    assign suspended = st.suspended;
    assign card_mode = st.card;
    assign gpio_mode = st.gpio_mode;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hard_pd_resets: assert property (!st.s2.rst_pd |=> !cpu_reset_n && !cse_reset_n && !afe_reset_n)
        else $error("hard power down did not hold resets");
    a_wake_delay: assert property (st.cpu == power_mode_manager_pkg::cpu_waking ##1
        st.cpu == power_mode_manager_pkg::cpu_normal |-> $past(st.wake_cnt) == 16'(WAKE_CYCLES - 1))
        else $error("wake delay wrong");
    a_pd_osc_off: assert property (st.cpu == power_mode_manager_pkg::cpu_pd |-> !osc_enable && cpu_reset_n)
        else $error("oscillator running in power down");
    a_active_field: assert property (rf_field_on |-> cse_enable && afe_enable && st.op ==
        power_mode_manager_pkg::op_initiator)
        else $error("field on outside active initiator");
    a_detector_only: assert property (rf_detector_enable |-> !cse_enable && !rf_field_on)
        else $error("detector mode wrong");
    a_after_reset: assert property ($rose(cpu_reset_n) |-> st.op == power_mode_manager_pkg::op_standby &&
        st.fe == power_mode_manager_pkg::front_end_deepest_off && !cse_enable && !rf_detector_enable)
        else $error("reset state not standby deepest");
    a_suspend_entry: assert property (st.cpu == power_mode_manager_pkg::cpu_normal && st.s2.rst_pd &&
        st.s2.hub_disabled |=> suspended && !rf_field_on)
        else $error("suspend not entered");
    a_low_to_input: assert property ($rose(st.cpu == power_mode_manager_pkg::cpu_pd) |->
        (gpio_mode & widen(st.low_mask)) == 32'h00000000)
        else $error("low pin not input in power down");
    a_restore_cfg: assert property (st.cpu == power_mode_manager_pkg::cpu_waking ##1
        st.cpu == power_mode_manager_pkg::cpu_normal |-> gpio_mode == st.gpio_saved)
        else $error("configuration not restored");
    a_abort_off: assert property (st.act_busy && cmd[`CMD_ABORT] && !st.s2.target_found |=> !rf_field_on)
        else $error("field on after abort");
    a_retry_off: assert property (st.act_busy && fail_edge && st.retry_left <= 8'h01 &&
        !st.s2.target_found |=> !rf_field_on ##1 !rf_field_on)
        else $error("field on after retries exhausted");
    c_activation_found: cover property (st.act_busy ##1 !st.act_busy && rf_field_on);
    c_power_down_wake: cover property (st.cpu == power_mode_manager_pkg::cpu_pd ##1
        st.cpu == power_mode_manager_pkg::cpu_waking);
    c_suspend: cover property ($rose(suspended));
    c_target_pd: cover property (rf_detector_enable);
endmodule

//--- test/apb_host_model.sv
`timescale 1ns/1ns
module apb_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [11:0] req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             req_done,
    output logic      [31:0] req_rdata,
    output logic             req_err,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [1:0] st;
    // setup, access until pready, then wait for release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= 2'h0;
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 12'h000;
            pwdata <= 32'h0;
            req_done <= 1'b0;
            req_rdata <= 32'h0;
            req_err <= 1'b0;
        end
        else if (st == 2'h0 && req_valid)
        begin
            psel <= 1'b1;
            pwrite <= req_write;
            paddr <= req_addr;
            pwdata <= req_wdata;
            st <= 2'h1;
        end
        else if (st == 2'h1)
        begin
            penable <= 1'b1;
            st <= 2'h2;
        end
        else if (st == 2'h2 && pready)
        begin
            req_rdata <= prdata;
            req_err <= pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            req_done <= 1'b1;
            st <= 2'h3;
        end
        else if (st == 2'h3)
        begin
            req_done <= 1'b0;
            if (!req_valid)
                st <= 2'h0;
        end
    end
endmodule

//--- test/power_mode_manager_tb.sv
`timescale 1ns/1ns
`include "power_mode_manager_defs.svh"
module power_mode_manager_tb;
    localparam int WK = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, gpio_mode, cfg, exp_pd, pins;
    logic        req_valid, req_write, req_done, req_err;
    logic [11:0] req_addr;
    logic [31:0] req_wdata, req_rdata;
    logic        pin_n, hub_off, host_susp, found, released, failed, wake;
    logic [7:0]  p3, p7;
    logic        cpu_rst_n, osc, cse_rst_n, afe_rst_n, cse_en, afe_en, det_en, field, act_req, susp;
    logic [1:0]  card_mode;
    int          bad_count, cmp_count, req_count;

    power_mode_manager #(.WAKE_CYCLES(WK)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_powerdown_pin(pin_n), .hub_port_disabled(hub_off),
        .host_suspend(host_susp), .target_found(found), .target_released(released),
        .attempt_failed(failed), .wake_event(wake), .port_three(p3), .port_seven(p7),
        .cpu_reset_n(cpu_rst_n), .osc_enable(osc), .cse_reset_n(cse_rst_n), .afe_reset_n(afe_rst_n),
        .cse_enable(cse_en), .afe_enable(afe_en), .rf_detector_enable(det_en), .rf_field_on(field),
        .activation_request(act_req), .suspended(susp), .card_mode(card_mode), .gpio_mode(gpio_mode));
    apb_host_model i_host (.pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
        .req_err(req_err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (act_req === 1'b1)
            req_count++;

    task report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (req_done !== 1'b1 && n < 50);
        req_valid <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task cmd(input int bitpos);
        bus(1'b1, `OFS_CMD, 32'h1 << bitpos);
        settle(4);
    endtask
    task status(input string name, input int lsb, input int w, input int exp);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk(name, (req_rdata >> lsb) & ((32'h1 << w) - 1), exp);
    endtask

    initial
    begin
        {presetn, req_valid, req_write, req_addr, req_wdata} = '0;
        {hub_off, host_susp, found, released, failed, wake, p3, p7} = '0;
        pin_n = 1'b1;
        void'($urandom(32'h6493));
        settle(4);
        presetn <= 1'b1;
        settle(6);
        chk("cpu_reset_n", cpu_rst_n, 1);
        chk("front end off", {cse_en, afe_en, det_en, field}, 0);
        chk("gpio_mode", gpio_mode, `GPIO_CFG_RESET);
        status("fe", 7, 3, 4);
        status("op", 10, 2, 0);
        bus(1'b0, `OFS_RETRY, 32'h0);
        chk("retry", req_rdata, `RETRY_RESET);
        bus(1'b0, 12'h040, 32'h0);
        chk("unmapped err", req_err, 1);
        chk("unmapped data", req_rdata, 0);
        bus(1'b1, `OFS_CARD, 32'h1);
        bus(1'b1, `OFS_CARD, 32'h3);
        settle(2);
        chk("card shutdown", card_mode, 1);
        bus(1'b1, `OFS_CARD, 32'h2);
        settle(2);
        chk("card normal", card_mode, 2);
        bus(1'b1, `OFS_RETRY, 32'h2);
        cmd(`CMD_ACTIVATE);
        chk("field on", {field, cse_en, afe_en}, 3'h7);
        status("op init", 10, 2, 1);
        repeat (2)
        begin
            failed <= 1'b1;
            settle(6);
            failed <= 1'b0;
            settle(3);
        end
        chk("requests", req_count, 2);
        chk("field exhausted", field, 0);
        status("op back", 10, 2, 0);
        cmd(`CMD_ACTIVATE);
        cmd(`CMD_ABORT);
        chk("field abort", field, 0);
        cmd(`CMD_ACTIVATE);
        found <= 1'b1;
        settle(6);
        chk("field found", field, 1);
        status("busy", 14, 1, 0);
        found <= 1'b0;
        cmd(`CMD_STANDBY);
        status("op standby", 10, 2, 0);
        cmd(`CMD_TARGET);
        status("op target", 10, 2, 2);
        chk("target fe", {cse_en, afe_en, field}, 3'h6);
        cfg = '0;
        for (int i = 0; i < 16; i++)
            cfg[2*i +: 2] = 2'($urandom % 3);
        pins = $urandom;
        exp_pd = cfg;
        for (int i = 0; i < 16; i++)
            if (!pins[i])
                exp_pd[2*i +: 2] = `GPIO_INPUT;
        p3 <= pins[7:0];
        p7 <= pins[15:8];
        bus(1'b1, `OFS_GPIO_CFG, cfg);
        settle(2);
        chk("gpio cfg", gpio_mode, cfg);
        cmd(`CMD_POWER_DOWN);
        chk("osc off", osc, 0);
        chk("gpio pd", gpio_mode, exp_pd);
        chk("detector only", {det_en, cse_en, field}, 3'h4);
        wake <= 1'b1;
        settle(4);
        wake <= 1'b0;
        settle(WK + 10);
        status("cpu normal", 4, 3, 1);
        chk("gpio restore", gpio_mode, cfg);
        bus(1'b0, `OFS_GPIO_SAVED, 32'h0);
        chk("gpio saved", req_rdata, cfg);
        released <= 1'b1;
        settle(6);
        released <= 1'b0;
        status("released", 10, 2, 0);
        host_susp <= 1'b1;
        settle(6);
        chk("suspend host", susp, 1);
        host_susp <= 1'b0;
        hub_off <= 1'b1;
        settle(6);
        chk("suspend hub", {susp, cse_en, field}, 3'h4);
        hub_off <= 1'b0;
        settle(6);
        chk("resume", susp, 0);
        cmd(`CMD_POWER_DOWN);
        status("cpu pd", 4, 3, 3);
        chk("pd deepest", {det_en, cse_en, field}, 0);
        cmd(`CMD_WAKE);
        settle(WK + 10);
        status("cpu woken", 4, 3, 1);
        chk("gpio woken", gpio_mode, cfg);
        pin_n <= 1'b0;
        settle(6);
        chk("hard pd", {cpu_rst_n, cse_rst_n, afe_rst_n, field, card_mode}, 0);
        report_and_stop();
    end
endmodule
